// ### srr_exec.sv
module srr_exec
   import srr_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                resetn,
   input  wire logic                instr_valid,
   input  srr_instr_t               instr,
   output logic                     instr_ready,
   input  wire logic [SRR_DW-1:0]   stk_top,
   output logic                     stk_push,
   output logic                     stk_pop,
   output logic [SRR_DW-1:0]        stk_wdata,
   output logic                     dmem_we,
   output logic [15:0]              dmem_addr,
   output logic [SRR_DW-1:0]        dmem_wdata,
   output logic                     ret_valid,
   output logic [SRR_DW-1:0]        ret_pc,
   output logic                     sleep_req,
   output logic                     idle_req,
   input  wire logic                wdt_timeout,
   input  wire logic                status_clr,
   output logic                     sleep_flag,
   output logic                     watchdog_timeout_flag,
   output srr_flags_t               flags,
   output logic                     repeat_active,
   input  wire logic [3:0]          w_peek_sel,
   output logic [SRR_DW-1:0]        w_peek_data
);

   typedef struct packed {
      srr_state_t                         st;
      logic [2:0]                         cnt;
      srr_instr_t                         held;
      logic [SRR_NREG-1:0][SRR_DW-1:0]    w;
      srr_flags_t                         fl;
      logic [15:0]                        rcount;
      logic                               rep_arm;
      logic [SRR_DW-1:0]                  ret_pc;
      logic                               sleep_f;
      logic                               watchdog_timeout_flag_f;
      logic                               sleep_p;
      logic                               idle_p;
      logic                               we;
      logic [15:0]                        addr;
      logic [SRR_DW-1:0]                  wdata;
   } srr_core_t;

   srr_core_t  s_q;
   srr_core_t  s_d;
   logic [1:0] rst_sync_q;
   logic       rst_n;
   default clocking core_cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // returns {carry, result} of a rotate or sign extension
   function automatic logic [16:0] srr_rotate(srr_op_t op,
                                              logic [15:0] v,
                                              logic c);
      unique case (op)
         SRR_OP_ROTL_C: return {v[15], v[14:0], c};
         SRR_OP_ROTL:   return {c, v[14:0], v[15]};
         SRR_OP_ROTR_C: return {v[0], c, v[15:1]};
         SRR_OP_ROTR:   return {c, v[0], v[15:1]};
         SRR_OP_SEXT:   return {~v[7], {8{v[7]}}, v[7:0]};
         default:     return {c, v};
      endcase
   endfunction : srr_rotate

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   srr_instr_t  cur;
   logic        go;
   logic        rep_ok;
   logic [15:0] src;
   logic [16:0] rot;
   always_comb
   begin
      s_d       = s_q;
      s_d.we    = 1'b0;
      s_d.sleep_p = 1'b0;
      s_d.idle_p  = 1'b0;
      stk_push  = 1'b0;
      stk_pop   = 1'b0;
      stk_wdata = '0;
      ret_valid = 1'b0;
      cur       = (s_q.st == SRR_ST_IDLE) ? instr : s_q.held;
      go        = (s_q.st == SRR_ST_IDLE) ? instr_valid
                                          : (s_q.st == SRR_ST_REP);
      src       = cur.src_w ? s_q.w[cur.ws] : cur.f_data;
      rot       = srr_rotate(cur.op, src, s_q.fl.c);
      rep_ok    = !(cur.op inside {SRR_OP_POP_D, SRR_OP_PUSH_D,
                                   SRR_OP_RET_LIT, SRR_OP_REP_L,
                                   SRR_OP_REP_W});
      if (status_clr)
      begin
         s_d.sleep_f = 1'b0;
         s_d.watchdog_timeout_flag_f  = 1'b0;
      end
      if (go)
      begin
         unique case (cur.op)
            SRR_OP_POP_W:
            begin
               s_d.w[cur.wd] = stk_top;
               stk_pop       = 1'b1;
            end
            SRR_OP_POP_F:
            begin
               s_d.we    = 1'b1;
               s_d.addr  = cur.f_addr;
               s_d.wdata = stk_top;
               stk_pop   = 1'b1;
            end
            SRR_OP_POP_D:
            begin
               s_d.w[cur.wd + 4'h1] = stk_top;
               stk_pop              = 1'b1;
            end
            SRR_OP_PUSH_W:
            begin
               stk_push  = 1'b1;
               stk_wdata = s_q.w[cur.ws];
            end
            SRR_OP_PUSH_F:
            begin
               stk_push  = 1'b1;
               stk_wdata = cur.f_data;
            end
            SRR_OP_PUSH_D:
            begin
               stk_push  = 1'b1;
               stk_wdata = s_q.w[cur.ws];
            end
            SRR_OP_PWR_SAVE:
            begin
               s_d.watchdog_timeout_flag_f  = 1'b0;
               s_d.sleep_f = ~cur.lit[0];
               s_d.sleep_p = ~cur.lit[0];
               s_d.idle_p  = cur.lit[0];
            end
            SRR_OP_REP_L:
            begin
               s_d.rcount  = {1'b0, cur.lit};
               s_d.rep_arm = 1'b1;
            end
            SRR_OP_REP_W:
            begin
               s_d.rcount  = s_q.w[cur.ws];
               s_d.rep_arm = 1'b1;
            end
            SRR_OP_RET_LIT:
            begin
               s_d.w[cur.wd] = {6'h00, cur.lit[9:0]};
               s_d.ret_pc    = stk_top;
               stk_pop       = 1'b1;
            end
            SRR_OP_NOP:
            begin
            end
            default:
            begin
               s_d.fl.n = rot[15];
               s_d.fl.z = (rot[15:0] == 16'h0000);
               if (cur.op inside {SRR_OP_ROTL_C, SRR_OP_ROTR_C, SRR_OP_SEXT})
                  s_d.fl.c = rot[16];
               if (cur.op == SRR_OP_SEXT)
                  s_d.w[cur.wd] = rot[15:0];
               else if (cur.dst == SRR_DST_F)
               begin
                  s_d.we    = 1'b1;
                  s_d.addr  = cur.f_addr;
                  s_d.wdata = rot[15:0];
               end
               else if (cur.dst == SRR_DST_W0)
                  s_d.w[0] = rot[15:0];
               else
                  s_d.w[cur.wd] = rot[15:0];
            end
         endcase
      end
      unique case (s_q.st)
         SRR_ST_IDLE:
         begin
            s_d.held = instr;
            if (go && s_q.rep_arm && !(cur.op inside {SRR_OP_REP_L,
                                                      SRR_OP_REP_W}))
            begin
               s_d.rep_arm = 1'b0;
               if (rep_ok && s_q.rcount != 16'h0000)
               begin
                  s_d.st     = SRR_ST_REP;
                  s_d.rcount = s_q.rcount - 16'h0001;
               end
               else
                  s_d.rcount = SRR_REP_RESET;
            end
            if (go && cur.op inside {SRR_OP_POP_D, SRR_OP_PUSH_D})
               s_d.st = SRR_ST_SECOND;
            if (go && cur.op == SRR_OP_RET_LIT)
            begin
               s_d.st  = SRR_ST_RET;
               s_d.cnt = (cur.short_ret ? SRR_RET_CYC_SH : SRR_RET_CYC)
                         - 3'h2;
            end
         end
         SRR_ST_SECOND:
         begin
            s_d.st = SRR_ST_IDLE;
            if (s_q.held.op == SRR_OP_POP_D)
            begin
               s_d.w[s_q.held.wd] = stk_top;
               stk_pop            = 1'b1;
            end
            else
            begin
               stk_push  = 1'b1;
               stk_wdata = s_q.w[s_q.held.ws + 4'h1];
            end
         end
         SRR_ST_RET:
         begin
            s_d.cnt = s_q.cnt - 3'h1;
            if (s_q.cnt == 3'h0)
            begin
               ret_valid = 1'b1;
               s_d.st    = SRR_ST_IDLE;
            end
         end
         SRR_ST_REP:
         begin
            if (s_q.rcount == 16'h0000)
               s_d.st = SRR_ST_IDLE;
            else
               s_d.rcount = s_q.rcount - 16'h0001;
         end
      endcase
      // timeout event wins over any clear in the same cycle
      if (wdt_timeout)
         s_d.watchdog_timeout_flag_f = 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q        <= '0;
         s_q.st     <= SRR_ST_IDLE;
         s_q.rcount <= SRR_REP_RESET;
         s_q.w      <= {SRR_NREG{SRR_W_RESET}};
      end
      else
         s_q <= s_d;
   end

   assign instr_ready           = rst_n && (s_q.st == SRR_ST_IDLE);
   assign dmem_we               = s_q.we;
   assign dmem_addr             = s_q.addr;
   assign dmem_wdata            = s_q.wdata;
   assign ret_pc                = s_q.ret_pc;
   assign sleep_req             = s_q.sleep_p;
   assign idle_req              = s_q.idle_p;
   assign sleep_flag            = s_q.sleep_f;
   assign watchdog_timeout_flag = s_q.watchdog_timeout_flag_f;
   assign flags                 = s_q.fl;
   assign repeat_active         = (s_q.st == SRR_ST_REP) || s_q.rep_arm;
   assign w_peek_data           = s_q.w[w_peek_sel];
   sequence s_take(srr_op_t o);
      instr_ready && instr_valid && instr.op == o;
   endsequence

   a_pop_w_flags: assert property (
      s_take(SRR_OP_POP_W) |-> stk_pop ##1 ($stable(flags)
         && s_q.w[$past(instr.wd)] == $past(stk_top)))
      else $error("register pop wrong");
   a_pop_f_write: assert property (
      s_take(SRR_OP_POP_F) |=> dmem_we && dmem_wdata == $past(stk_top)
         && $stable(flags))
      else $error("file pop wrong");
   a_pop_d_two: assert property (
      s_take(SRR_OP_POP_D) |-> stk_pop ##1 (stk_pop && !instr_ready)
         ##1 (instr_ready && $stable(flags)))
      else $error("double pop not two cycles");
   a_push_w_data: assert property (
      s_take(SRR_OP_PUSH_W) |-> stk_push
         && stk_wdata == s_q.w[instr.ws])
      else $error("register push data wrong");
   a_push_f_data: assert property (
      s_take(SRR_OP_PUSH_F) |-> stk_push && stk_wdata == instr.f_data)
      else $error("file push data wrong");
   a_push_d_two: assert property (
      s_take(SRR_OP_PUSH_D) |-> stk_push ##1 (stk_push
         && stk_wdata == s_q.w[$past(instr.ws) + 4'h1]))
      else $error("double push second word wrong");
   a_power_save: assert property (
      s_take(SRR_OP_PWR_SAVE) |=> (idle_req == $past(instr.lit[0]))
         && (sleep_req == !$past(instr.lit[0])))
      else $error("power save mode wrong");
   a_rep_lit_load: assert property (
      s_take(SRR_OP_REP_L) |=> s_q.rcount == {1'b0, $past(instr.lit)})
      else $error("repeat count not loaded");
   a_ret_long: assert property (
      s_take(SRR_OP_RET_LIT) ##0 !instr.short_ret |-> !ret_valid [*5]
         ##1 ret_valid)
      else $error("return not on sixth cycle");
   a_rotl_carry: assert property (
      s_take(SRR_OP_ROTL_C) |=> flags.c == $past(src[15]))
      else $error("rotate carry wrong");
   a_rotl_keep: assert property (
      s_take(SRR_OP_ROTL) |=> $stable(flags.c))
      else $error("carry changed");
   a_sext_flags: assert property (
      s_take(SRR_OP_SEXT) |=> flags.n == $past(src[7])
         && flags.c == !$past(src[7]))
      else $error("sign extend flags wrong");
   a_rep_end: assert property (
      s_q.st == SRR_ST_REP && s_q.rcount == 16'h0000 |=> instr_ready)
      else $error("repeat did not end");
endmodule : srr_exec

// ### srr_exec_tb.sv
module srr_exec_tb
   import srr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk, resetn, instr_valid, instr_ready, stk_push, stk_pop;
   logic dmem_we, ret_valid, sleep_req, idle_req, wdt_timeout, status_clr;
   logic sleep_flag, watchdog_timeout_flag, repeat_active;
   logic [15:0] stk_top, stk_wdata, dmem_addr, dmem_wdata, ret_pc;
   logic [15:0] w_peek_data;
   logic [3:0]  w_peek_sel;
   srr_instr_t  instr;
   srr_flags_t  flags;
   logic [2:0]  ef;
   int          fail_count, n_tests;

   srr_exec u_srr_exec (.core_clk(core_clk), .resetn(resetn),
      .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
      .stk_top(stk_top), .stk_push(stk_push), .stk_pop(stk_pop),
      .stk_wdata(stk_wdata), .dmem_we(dmem_we), .dmem_addr(dmem_addr),
      .dmem_wdata(dmem_wdata), .ret_valid(ret_valid), .ret_pc(ret_pc),
      .sleep_req(sleep_req), .idle_req(idle_req),
      .wdt_timeout(wdt_timeout), .status_clr(status_clr),
      .sleep_flag(sleep_flag),
      .watchdog_timeout_flag(watchdog_timeout_flag), .flags(flags),
      .repeat_active(repeat_active), .w_peek_sel(w_peek_sel),
      .w_peek_data(w_peek_data));

   srr_stack_model u_srr_stack_model (.core_clk(core_clk),
      .resetn(resetn), .stk_push(stk_push), .stk_pop(stk_pop),
      .stk_wdata(stk_wdata), .stk_top(stk_top));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic summarize();
      if (fail_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic check(input string name, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   function automatic srr_instr_t mk(srr_op_t op, logic [3:0] ws, wd,
                                     logic [14:0] lit, logic [15:0] fd);
      srr_instr_t i;
      i        = '0;
      i.op     = op;
      i.dst    = SRR_DST_WD;
      i.src_w  = 1'b1;
      i.ws     = ws;
      i.wd     = wd;
      i.lit    = lit;
      i.f_data = fd;
      return i;
   endfunction : mk

   // expected {c,n,z,result} of a rotate or sign extension
   function automatic logic [18:0] rot(srr_op_t op, logic [15:0] v,
                                       logic ci);
      logic [15:0] r;
      logic        c;
      case (op)
         SRR_OP_ROTL_C: {c, r} = {v[15], v[14:0], ci};
         SRR_OP_ROTL:   {c, r} = {ci, v[14:0], v[15]};
         SRR_OP_ROTR_C: {c, r} = {v[0], ci, v[15:1]};
         SRR_OP_ROTR:   {c, r} = {ci, v[0], v[15:1]};
         default:       {c, r} = {~v[7], {8{v[7]}}, v[7:0]};
      endcase
      return {c, r[15], r == 16'h0000, r};
   endfunction : rot

   task automatic wait_ready();
      int k;
      k = 0;
      while (instr_ready !== 1'b1)
      begin
         if (k == 100)
         begin
            fail_count++;
            summarize();
         end
         k++;
         @(negedge core_clk);
      end
   endtask : wait_ready

   // returns in the cycle after the taking edge
   task automatic issue(input srr_instr_t i);
      @(negedge core_clk);
      wait_ready();
      instr       = i;
      instr_valid = 1'b1;
      @(negedge core_clk);
      instr_valid = 1'b0;
   endtask : issue

   task automatic peek(input logic [3:0] s, output logic [15:0] v);
      w_peek_sel = s;
      #1;
      v = w_peek_data;
   endtask : peek

   task automatic setw(input logic [3:0] wd, input logic [15:0] val);
      srr_instr_t i;
      i       = mk(SRR_OP_PUSH_F, 4'h0, 4'h0, 15'h0000, val);
      i.src_w = 1'b0;
      issue(i);
      issue(mk(SRR_OP_POP_W, 4'h0, wd, 15'h0000, 16'h0000));
   endtask : setw

   task automatic t_rotate();
      srr_op_t     ops[8] = '{SRR_OP_ROTL_C, SRR_OP_ROTL, SRR_OP_ROTR_C,
         SRR_OP_ROTR_C, SRR_OP_ROTR, SRR_OP_SEXT, SRR_OP_SEXT, SRR_OP_ROTL};
      logic [15:0] vals[8] = '{16'h8001, 16'h8001, 16'h0001, 16'h0000,
         16'h0001, 16'h0080, 16'h007F, 16'h0000};
      srr_dst_t    dsts[8] = '{SRR_DST_WD, SRR_DST_W0, SRR_DST_F,
         SRR_DST_WD, SRR_DST_WD, SRR_DST_WD, SRR_DST_WD, SRR_DST_W0};
      srr_instr_t  i;
      logic [18:0] e;
      logic [15:0] v;
      for (int j = 0; j < 8; j++)
      begin
         setw(4'h1, vals[j]);
         i        = mk(ops[j], 4'h1, 4'h3, 15'h0000, 16'h0000);
         i.dst    = dsts[j];
         i.f_addr = 16'h0040 + 16'(j);
         e        = rot(ops[j], vals[j], ef[2]);
         ef       = e[18:16];
         issue(i);
         check("rot flags", {13'h0000, flags}, {13'h0000, ef});
         if (dsts[j] == SRR_DST_F)
         begin
            check("rot file", {dmem_we, dmem_addr}, {1'b1, i.f_addr});
            check("rot fdata", dmem_wdata, e[15:0]);
         end
         else
         begin
            peek((dsts[j] == SRR_DST_W0) ? 4'h0 : 4'h3, v);
            check("rot result", v, e[15:0]);
         end
      end
   endtask : t_rotate

   task automatic t_stack();
      logic [15:0] v;
      srr_instr_t  i;
      setw(4'h2, 16'hA5C3);
      peek(4'h2, v);
      check("pop word", v, 16'hA5C3);
      check("pop flags", {13'h0000, flags}, {13'h0000, ef});
      issue(mk(SRR_OP_PUSH_W, 4'h2, 4'h0, 15'h0000, 16'h0000));
      check("push flags", {13'h0000, flags}, {13'h0000, ef});
      i        = mk(SRR_OP_POP_F, 4'h0, 4'h0, 15'h0000, 16'h0000);
      i.src_w  = 1'b0;
      i.f_addr = 16'h0123;
      issue(i);
      check("popf addr", {dmem_we, dmem_addr}, 17'h10123);
      check("popf data", dmem_wdata, 16'hA5C3);
      check("popf flags", {13'h0000, flags}, {13'h0000, ef});
   endtask : t_stack

   task automatic t_double();
      logic [15:0] v;
      setw(4'h4, 16'h1111);
      setw(4'h5, 16'h2222);
      issue(mk(SRR_OP_PUSH_D, 4'h4, 4'h0, 15'h0000, 16'h0000));
      check("pushd busy", {15'h0000, instr_ready}, 16'h0000);
      issue(mk(SRR_OP_POP_D, 4'h0, 4'h6, 15'h0000, 16'h0000));
      check("popd busy", {15'h0000, instr_ready}, 16'h0000);
      @(negedge core_clk);
      peek(4'h6, v);
      check("popd low", v, 16'h1111);
      peek(4'h7, v);
      check("popd high", v, 16'h2222);
      check("dbl flags", {13'h0000, flags}, {13'h0000, ef});
   endtask : t_double

   task automatic t_power();
      @(negedge core_clk);
      wdt_timeout = 1'b1;
      @(negedge core_clk);
      wdt_timeout = 1'b0;
      check("wdt set", {15'h0000, watchdog_timeout_flag}, 16'h0001);
      issue(mk(SRR_OP_PWR_SAVE, 4'h0, 4'h0, 15'h0000, 16'h0000));
      check("sleep", {12'h000, sleep_req, idle_req, sleep_flag,
            watchdog_timeout_flag}, 16'h000A);
      @(negedge core_clk);
      status_clr = 1'b1;
      @(negedge core_clk);
      status_clr = 1'b0;
      check("clear", {15'h0000, sleep_flag}, 16'h0000);
      issue(mk(SRR_OP_PWR_SAVE, 4'h0, 4'h0, 15'h0001, 16'h0000));
      check("idle", {12'h000, sleep_req, idle_req, sleep_flag,
            watchdog_timeout_flag}, 16'h0004);
   endtask : t_power

   task automatic t_repeat();
      int          runs[3] = '{4, 1, 3};
      logic [15:0] v;
      setw(4'h2, 16'h0002);
      for (int j = 0; j < 3; j++)
      begin
         setw(4'h1, 16'h0001);
         if (j == 2)
            issue(mk(SRR_OP_REP_W, 4'h2, 4'h2, 15'h0000, 16'h0000));
         else
            issue(mk(SRR_OP_REP_L, 4'h0, 4'h0, (j == 0) ? 15'h0003 : 15'h0000,
                     16'h0000));
         if (j != 1)
            check("rep armed", {15'h0000, repeat_active}, 16'h0001);
         issue(mk(SRR_OP_ROTL, 4'h1, 4'h1, 15'h0000, 16'h0000));
         if (j != 1)
            check("rep busy", {15'h0000, instr_ready}, 16'h0000);
         wait_ready();
         peek(4'h1, v);
         check("rep count", v, 16'h0001 << runs[j]);
         check("rep done", {15'h0000, repeat_active}, 16'h0000);
      end
   endtask : t_repeat

   task automatic t_return();
      srr_instr_t  i;
      logic [15:0] v;
      int          n;
      for (int s = 0; s < 2; s++)
      begin
         i       = mk(SRR_OP_PUSH_F, 4'h0, 4'h0, 15'h0000, 16'h0ABC + 16'(s));
         i.src_w = 1'b0;
         issue(i);
         i = mk(SRR_OP_RET_LIT, 4'h0, 4'h9, (s == 0) ? 15'h03FF : 15'h0155,
                16'h0000);
         i.short_ret = s[0];
         issue(i);
         n = 1;
         while (ret_valid !== 1'b1 && n < 20)
         begin
            @(negedge core_clk);
            n++;
         end
         check("ret cycles", 16'(n), (s == 0) ? 16'(SRR_RET_CYC - 3'h1) :
               16'(SRR_RET_CYC_SH - 3'h1));
         check("ret pc", ret_pc, 16'h0ABC + 16'(s));
         @(negedge core_clk);
         peek(4'h9, v);
         check("ret lit", v, (s == 0) ? 16'h03FF : 16'h0155);
      end
   endtask : t_return

   initial
   begin
      resetn      = 1'b0;
      instr_valid = 1'b0;
      instr       = '0;
      wdt_timeout = 1'b0;
      status_clr  = 1'b0;
      w_peek_sel  = 4'h0;
      ef          = 3'h0;
      fail_count  = 0;
      n_tests     = 0;
      repeat (16) @(negedge core_clk);
      resetn = 1'b1;
      t_rotate();
      t_stack();
      t_double();
      t_power();
      t_repeat();
      t_return();
      summarize();
   end
endmodule : srr_exec_tb

// ### srr_pkg.sv
// What this block does
// - pop to working register, one cycle, flags kept
// - pop to file register, one cycle, flags kept
// - double pop fills register pair, two cycles
// - push working register, one cycle, flags kept
// - push file register, one cycle, flags kept
// - double push stores register pair, two cycles
// - power save picks sleep/idle, updates status
// - literal repeat runs next instruction lit+1 times
// - register repeat runs next instruction Wn+1 times
// - return literal loads Wn, six or five cycles
// - rotate left through carry, updates C N Z
// - rotate left no carry, updates N Z
// - rotate right no carry, updates N Z
// - sign extend low byte, updates C N Z
package srr_pkg;
   localparam int          SRR_DW          = 16;
   localparam int          SRR_NREG        = 16;
   localparam logic [2:0]  SRR_RET_CYC     = 3'h6;
   localparam logic [2:0]  SRR_RET_CYC_SH  = 3'h5;
   localparam logic [15:0] SRR_REP_RESET   = 16'h0000;
   localparam logic [15:0] SRR_W_RESET     = 16'h0000;

   typedef enum logic [3:0] {
      SRR_OP_NOP      = 4'h0,
      SRR_OP_POP_W    = 4'h1,
      SRR_OP_POP_F    = 4'h2,
      SRR_OP_POP_D    = 4'h3,
      SRR_OP_PUSH_W   = 4'h4,
      SRR_OP_PUSH_F   = 4'h5,
      SRR_OP_PUSH_D   = 4'h6,
      SRR_OP_PWR_SAVE = 4'h7,
      SRR_OP_REP_L    = 4'h8,
      SRR_OP_REP_W    = 4'h9,
      SRR_OP_RET_LIT  = 4'hA,
      SRR_OP_ROTL_C   = 4'hB,
      SRR_OP_ROTL     = 4'hC,
      SRR_OP_ROTR_C   = 4'hD,
      SRR_OP_ROTR     = 4'hE,
      SRR_OP_SEXT     = 4'hF
   } srr_op_t;

   typedef enum logic [1:0] {
      SRR_DST_F  = 2'h0,
      SRR_DST_W0 = 2'h1,
      SRR_DST_WD = 2'h2
   } srr_dst_t;

   typedef enum logic [1:0] {
      SRR_ST_IDLE   = 2'h0,
      SRR_ST_SECOND = 2'h1,
      SRR_ST_RET    = 2'h2,
      SRR_ST_REP    = 2'h3
   } srr_state_t;

   typedef struct packed {
      srr_op_t     op;
      srr_dst_t    dst;
      logic        src_w;
      logic [3:0]  ws;
      logic [3:0]  wd;
      logic [15:0] f_addr;
      logic [15:0] f_data;
      logic [14:0] lit;
      logic        short_ret;
   } srr_instr_t;

   typedef struct packed {
      logic c;
      logic n;
      logic z;
   } srr_flags_t;
endpackage : srr_pkg

// ### srr_stack_model.sv
module srr_stack_model
   import srr_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              resetn,
   input  wire logic              stk_push,
   input  wire logic              stk_pop,
   input  wire logic [SRR_DW-1:0] stk_wdata,
   output logic      [SRR_DW-1:0] stk_top
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [SRR_DW-1:0] mem [0:15];
   logic [4:0]        sp_q;
   logic [SRR_DW-1:0] junk_q;

   // an empty stack shows a word that changes every cycle
   assign stk_top = (sp_q == 5'h00) ? junk_q : mem[sp_q[3:0] - 4'h1];

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sp_q   <= 5'h00;
         junk_q <= 16'h5A5A;
      end
      else
      begin
         junk_q <= ~junk_q;
         if (stk_push)
         begin
            mem[sp_q[3:0]] <= stk_wdata;
            sp_q           <= sp_q + 5'h01;
         end
         else if (stk_pop && sp_q != 5'h00)
            sp_q <= sp_q - 5'h01;
      end
   end
endmodule : srr_stack_model
